// [hdl/uml_defs.svh]
`ifndef UML_DEFS_SVH
`define UML_DEFS_SVH

// register offsets on the 3-bit port address
`define UML_OFF_HANDSHAKE_CONTROL 3'h4
`define UML_OFF_LINE_CONDITION 3'h5
`define UML_OFF_HANDSHAKE_CONDITION 3'h6
`define UML_OFF_SCRATCH_BYTE 3'h7

// handshake_control fields
`define UML_HC_TERMINAL_READY 0
`define UML_HC_REQUEST_SEND 1
`define UML_HC_AUX_BIT_ONE 2
`define UML_HC_IRQ_GATE_BIT 3
`define UML_HC_LOOPBACK 4
`define UML_HC_WIDTH 5

// line_condition fields
`define UML_LC_DATA_READY 0
`define UML_LC_OVERRUN 1
`define UML_LC_PARITY_FLAG 2
`define UML_LC_FRAMING_FLAG 3
`define UML_LC_BREAK_FLAG 4
`define UML_LC_HOLDING_EMPTY 5
`define UML_LC_TRANSMITTER_IDLE 6
`define UML_LC_FIFO_ERROR 7

// reset values
`define UML_RST_HANDSHAKE_CONTROL 5'h00
`define UML_RST_SCRATCH_BYTE 8'h00
`define UML_RST_BYTE 8'h00

`endif

// [hdl/uml_pkg.sv]
`default_nettype none
package uml_pkg;
  typedef logic [7:0] uml_byte_type;
  typedef logic [2:0] uml_addr_type;
  // error tag kept beside each received character
  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
  } uml_err_type;
  // four handshake lines, ordered as the delta bits
  typedef struct packed {
    logic carrier;
    logic ring;
    logic set_ready;
    logic clear_send;
  } uml_lines_type;
endpackage : uml_pkg
`default_nettype wire

// [hdl/uml_top.sv]
// Operation
// - control bits 0,1 drive low-active handshake pins
// - aux bit one drives no pin; in loopback it feeds ring status
// - gate bit enables interrupt output driver
// - loopback: serial out mark, tx into rx
// - loopback: control bits feed status, pins high
// - loopback modem events come from control bits
// - control bits 5 to 7 read zero
// - data ready follows receive buffer contents
// - overrun when unread character is overwritten
// - line status read clears bits 1 to 4
// - parity flag on received parity mismatch
// - fifo errors reported at fifo head
// - framing flag on zero stop bit
// - receiver resyncs on framing error start bit
// - break flag, one zero char, half-bit mark
// - bits 1 to 4 raise line interrupt
// - holding empty flag and its interrupt
// - transmitter idle when holding and shifter empty
// - bit 7 flags queued fifo errors
// - delta bits latch line changes, read clears
// - delta bits raise modem status interrupt
// - status bits 4 to 7 show lines
//
// Implementation choice: the plain strobed port.
`include "uml_defs.svh"
`default_nettype none
module uml_top #(
  parameter int ADDR_BITS = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire uml_pkg::uml_addr_type i_addr,
  input wire uml_pkg::uml_byte_type i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output uml_pkg::uml_byte_type o_rd_data,
  input wire logic i_fifo_mode,
  input wire logic i_rx_done,
  input wire logic i_rx_parity_bad,
  input wire logic i_rx_frame_bad,
  input wire logic i_rx_break,
  input wire logic i_rx_full,
  input wire logic i_rx_store,
  input wire logic i_rx_pop,
  input wire logic i_rx_empty,
  input wire logic i_tx_hold_empty,
  input wire logic i_tx_shift_empty,
  input wire logic i_tx_serial,
  input wire logic i_serial_in,
  output logic o_serial_out,
  output logic o_rx_serial,
  output logic o_loopback,
  input wire logic i_clear_send_pin_n,
  input wire logic i_set_ready_pin_n,
  input wire logic i_ring_pin_n,
  input wire logic i_carrier_pin_n,
  output logic o_terminal_ready_pin_n,
  output logic o_request_send_pin_n,
  input wire logic i_line_irq_en,
  input wire logic i_holding_empty_irq_en,
  input wire logic i_modem_irq_en,
  input wire logic i_port_irq,
  output logic o_line_irq_req,
  output logic o_holding_empty_irq_req,
  output logic o_modem_irq_req,
  output logic o_irq,
  output logic o_irq_oe
);
  import uml_pkg::*;

  localparam int DEPTH = 1 << ADDR_BITS;
  // sized copies so the queue compares stay at counter width
  localparam logic [ADDR_BITS:0] FULL_COUNT = (ADDR_BITS + 1)'(DEPTH);
  localparam logic [ADDR_BITS:0] ONE_ENTRY = (ADDR_BITS + 1)'(1);

  logic [`UML_HC_WIDTH-1:0] handshake_control;
  uml_byte_type scratch_byte;
  logic data_ready;
  logic overrun;
  logic parity_flag;
  logic framing_flag;
  logic break_flag;
  logic holding_empty;
  logic transmitter_idle;
  logic fifo_error;
  uml_lines_type line_state;
  uml_lines_type line_prev;
  uml_lines_type line_changed;
  uml_lines_type next_line_state;

  uml_err_type tags [DEPTH];
  logic [ADDR_BITS-1:0] wr_ptr;
  logic [ADDR_BITS-1:0] rd_ptr;
  logic [ADDR_BITS:0] count;
  logic [ADDR_BITS:0] err_count;
  logic [ADDR_BITS:0] next_err_count;

  logic loop;
  logic rd_line;
  logic rd_hs;
  logic push;
  logic pop;
  logic head_event;
  uml_err_type new_tag;
  uml_err_type head_tag;
  uml_err_type err_set;
  uml_byte_type line_value;
  uml_byte_type hs_value;

  assign loop = handshake_control[`UML_HC_LOOPBACK];
  assign rd_line = i_rd && (i_addr == `UML_OFF_LINE_CONDITION);
  assign rd_hs = i_rd && (i_addr == `UML_OFF_HANDSHAKE_CONDITION);
  assign new_tag = '{brk: i_rx_break, framing: i_rx_frame_bad, parity: i_rx_parity_bad};

  // register writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      handshake_control <= `UML_RST_HANDSHAKE_CONTROL;
    end else if (i_wr && i_addr == `UML_OFF_HANDSHAKE_CONTROL) begin
      handshake_control <= i_wr_data[`UML_HC_WIDTH-1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scratch_byte <= `UML_RST_SCRATCH_BYTE;
    end else if (i_wr && i_addr == `UML_OFF_SCRATCH_BYTE) begin
      scratch_byte <= i_wr_data;
    end
  end

  // pins and loopback routing
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_terminal_ready_pin_n <= 1'b1;
      o_request_send_pin_n <= 1'b1;
      o_serial_out <= 1'b1;
      o_rx_serial <= 1'b1;
      o_loopback <= 1'b0;
    end else begin
      o_terminal_ready_pin_n <= loop | ~handshake_control[`UML_HC_TERMINAL_READY];
      o_request_send_pin_n <= loop | ~handshake_control[`UML_HC_REQUEST_SEND];
      o_serial_out <= loop | i_tx_serial;
      o_rx_serial <= loop ? i_tx_serial : i_serial_in;
      o_loopback <= loop;
    end
  end

  // interrupt output driver; gate low floats the line
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_irq_oe <= 1'b0;
    end else begin
      o_irq <= i_port_irq & handshake_control[`UML_HC_IRQ_GATE_BIT];
      o_irq_oe <= handshake_control[`UML_HC_IRQ_GATE_BIT];
    end
  end

  // error tags queued beside receive fifo entries
  assign push = i_fifo_mode && i_rx_store && (count != FULL_COUNT);
  assign pop = i_fifo_mode && i_rx_pop && (count != '0);

  generate
    for (genvar gi = 0; gi < DEPTH; gi++) begin : g_tag
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          tags[gi] <= '0;
        end else if (push && wr_ptr == ADDR_BITS'(gi)) begin
          tags[gi] <= new_tag;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (!i_fifo_mode) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{ADDR_BITS{1'b0}}, push} - {{ADDR_BITS{1'b0}}, pop};
    end
  end

  // next head entry; a push into a one-deep queue while popping lands at head
  always_comb begin
    head_event = 1'b0;
    head_tag = '0;
    if (push && count == '0) begin
      head_event = 1'b1;
      head_tag = new_tag;
    end else if (pop && count > ONE_ENTRY) begin
      head_event = 1'b1;
      head_tag = tags[rd_ptr + 1'b1];
    end else if (pop && push) begin
      head_event = 1'b1;
      head_tag = new_tag;
    end
  end

  always_comb begin
    next_err_count = err_count;
    if (push && (|new_tag)) begin
      next_err_count = next_err_count + 1'b1;
    end
    if (pop && (|tags[rd_ptr])) begin
      next_err_count = next_err_count - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      err_count <= '0;
    end else begin
      err_count <= i_fifo_mode ? next_err_count : '0;
    end
  end

  // error flags: fifo mode shows the head entry, otherwise the last character
  always_comb begin
    err_set = '0;
    if (i_fifo_mode) begin
      if (head_event) begin
        err_set = head_tag;
      end
    end else if (i_rx_done) begin
      err_set = new_tag;
    end
  end

  // sticky error flags; set beats the read clear
  logic [3:0] sticky_set;
  wire logic [3:0] sticky_bits;

  assign sticky_set = {err_set.brk, err_set.framing, err_set.parity,
    i_rx_done && i_rx_full};

  generate
    for (genvar fi = 0; fi < 4; fi++) begin : g_sticky
      logic held;
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          held <= 1'b0;
        end else begin
          held <= sticky_set[fi] || (held && !rd_line);
        end
      end
      assign sticky_bits[fi] = held;
    end
  endgenerate

  // receiver resync and break timing live in the shifter
  assign overrun = sticky_bits[0];
  assign parity_flag = sticky_bits[1];
  assign framing_flag = sticky_bits[2];
  assign break_flag = sticky_bits[3];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fifo_error <= 1'b0;
    end else if (!i_fifo_mode) begin
      fifo_error <= 1'b0;
    end else if ((push && (|new_tag)) || !rd_line) begin
      fifo_error <= fifo_error || (next_err_count != '0);
    end else begin
      fifo_error <= next_err_count != '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_ready <= 1'b0;
      holding_empty <= 1'b1;
      transmitter_idle <= 1'b1;
    end else begin
      data_ready <= !i_rx_empty;
      holding_empty <= i_tx_hold_empty;
      transmitter_idle <= i_tx_hold_empty && i_tx_shift_empty;
    end
  end

  // handshake line state; loopback takes the control bits instead of pins
  always_comb begin
    if (loop) begin
      next_line_state.clear_send = handshake_control[`UML_HC_REQUEST_SEND];
      next_line_state.set_ready = handshake_control[`UML_HC_TERMINAL_READY];
      next_line_state.ring = handshake_control[`UML_HC_AUX_BIT_ONE];
      next_line_state.carrier = handshake_control[`UML_HC_IRQ_GATE_BIT];
    end else begin
      next_line_state.clear_send = ~i_clear_send_pin_n;
      next_line_state.set_ready = ~i_set_ready_pin_n;
      next_line_state.ring = ~i_ring_pin_n;
      next_line_state.carrier = ~i_carrier_pin_n;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      line_state <= '0;
      line_prev <= '0;
    end else begin
      line_state <= next_line_state;
      line_prev <= line_state;
    end
  end

  // bit 2 is ring; it counts only when the active ring ends
  wire logic [3:0] delta_bits;

  generate
    for (genvar li = 0; li < 4; li++) begin : g_delta
      logic seen;
      logic hit;
      if (li == 2) begin : g_ring
        assign hit = line_prev[li] && !line_state[li];
      end else begin : g_level
        assign hit = line_state[li] ^ line_prev[li];
      end
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          seen <= 1'b0;
        end else begin
          seen <= hit || (seen && !rd_hs);
        end
      end
      assign delta_bits[li] = seen;
    end
  endgenerate

  assign line_changed = delta_bits;

  // interrupt requests toward the identification logic
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_line_irq_req <= 1'b0;
      o_holding_empty_irq_req <= 1'b0;
      o_modem_irq_req <= 1'b0;
    end else begin
      o_line_irq_req <= i_line_irq_en &&
        (overrun || parity_flag || framing_flag || break_flag);
      o_holding_empty_irq_req <= i_holding_empty_irq_en && holding_empty;
      o_modem_irq_req <= i_modem_irq_en && (|line_changed);
    end
  end

  // read path
  assign line_value = {fifo_error, transmitter_idle, holding_empty, break_flag,
    framing_flag, parity_flag, overrun, data_ready};
  assign hs_value = {line_state.carrier, line_state.ring, line_state.set_ready,
    line_state.clear_send, line_changed.carrier, line_changed.ring,
    line_changed.set_ready, line_changed.clear_send};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= `UML_RST_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        `UML_OFF_HANDSHAKE_CONTROL: o_rd_data <= {3'h0, handshake_control};
        `UML_OFF_LINE_CONDITION: o_rd_data <= line_value;
        `UML_OFF_HANDSHAKE_CONDITION: o_rd_data <= hs_value;
        `UML_OFF_SCRATCH_BYTE: o_rd_data <= scratch_byte;
        default: o_rd_data <= `UML_RST_BYTE;
      endcase
    end else begin
      o_rd_data <= `UML_RST_BYTE;
    end
  end

endmodule : uml_top
`default_nettype wire

// [test/uml_properties.sv]
`default_nettype none
module uml_properties (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire uml_pkg::uml_addr_type i_addr,
  input wire uml_pkg::uml_byte_type i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire uml_pkg::uml_byte_type o_rd_data,
  input wire logic i_rx_done,
  input wire logic i_rx_full,
  input wire logic i_line_irq_en,
  input wire logic o_line_irq_req,
  input wire logic i_modem_irq_en,
  input wire logic o_modem_irq_req,
  input wire logic i_clear_send_pin_n,
  input wire logic i_set_ready_pin_n,
  input wire logic i_ring_pin_n,
  input wire logic i_carrier_pin_n,
  input wire logic o_terminal_ready_pin_n,
  input wire logic o_request_send_pin_n,
  input wire logic o_loopback,
  input wire logic o_serial_out,
  input wire logic o_rx_serial,
  input wire logic i_tx_serial,
  input wire logic i_serial_in,
  input wire logic i_port_irq,
  input wire logic o_irq,
  input wire logic o_irq_oe,
  input wire logic i_holding_empty_irq_en,
  input wire logic i_tx_hold_empty,
  input wire logic o_holding_empty_irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lines;
  assign lines = {i_carrier_pin_n, i_ring_pin_n, i_set_ready_pin_n, i_clear_send_pin_n};
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  hi_zero_a: assert property (i_rd && i_addr == 3'h4 |=> o_rd_data[7:5] == 3'h0)
    else $error("control read shows upper bits");
  dtr_pin_a: assert property (i_wr && i_addr == 3'h4 |-> ##2
    o_terminal_ready_pin_n == ($past(i_wr_data[4], 2) | ~$past(i_wr_data[0], 2)))
    else $error("terminal ready pin wrong");
  rts_pin_a: assert property (i_wr && i_addr == 3'h4 |-> ##2
    o_request_send_pin_n == ($past(i_wr_data[4], 2) | ~$past(i_wr_data[1], 2)))
    else $error("request send pin wrong");
  gate_oe_a: assert property (i_wr && i_addr == 3'h4 |-> ##2 o_irq_oe == $past(i_wr_data[3], 2))
    else $error("interrupt driver enable wrong");
  irq_pass_a: assert property (o_irq == ($past(i_port_irq) & o_irq_oe))
    else $error("interrupt output not gated");
  tx_mark_a: assert property (o_loopback |-> o_serial_out)
    else $error("serial out not at mark in loopback");
  rx_loop_a: assert property (o_rx_serial == (o_loopback ? $past(i_tx_serial) : $past(i_serial_in)))
    else $error("receiver input source wrong");
  overrun_irq_a: assert property (i_rx_done && i_rx_full && i_line_irq_en |-> ##2 o_line_irq_req)
    else $error("overrun raised no line request");
  delta_irq_a: assert property ($changed(i_clear_send_pin_n) && !o_loopback && i_modem_irq_en
    |-> ##3 o_modem_irq_req)
    else $error("line change raised no modem request");
  status_lines_a: assert property (i_rd && i_addr == 3'h6 && !o_loopback && $stable(lines)
    |=> o_rd_data[7:4] == ~$past(lines))
    else $error("status bits do not show lines");
  holding_empty_irq_a: assert property (!$past(i_rst) && !$past(i_rst, 2) |->
    o_holding_empty_irq_req == ($past(i_holding_empty_irq_en) && $past(i_tx_hold_empty, 2)))
    else $error("holding empty request wrong");
  cover property (o_loopback && o_rx_serial != o_serial_out);
  cover property (o_modem_irq_req);
  cover property (o_line_irq_req);
endmodule : uml_properties
bind uml_top uml_properties chk (.*);
`default_nettype wire

// [test/uml_modem.sv]
`default_nettype none
module uml_modem (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic [1:0] i_toggle,
  input wire logic i_terminal_ready_pin_n,
  input wire logic i_request_send_pin_n,
  output logic o_clear_send_pin_n,
  output logic o_set_ready_pin_n,
  output var logic o_ring_pin_n,
  output var logic o_carrier_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] echo;
  // a slow modem answers four clocks late, so the port must not expect it at once
  assign o_clear_send_pin_n = i_slow ? echo[7] : echo[1];
  assign o_set_ready_pin_n = i_slow ? echo[6] : echo[0];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      echo <= 8'hff;
      o_ring_pin_n <= 1'b1;
      o_carrier_pin_n <= 1'b1;
    end else begin
      echo <= {echo[5:0], i_request_send_pin_n, i_terminal_ready_pin_n};
      o_ring_pin_n <= o_ring_pin_n ^ i_toggle[0];
      o_carrier_pin_n <= o_carrier_pin_n ^ i_toggle[1];
    end
  end
endmodule : uml_modem
`default_nettype wire

// [test/tb_top.sv]
`default_nettype none
module tb_top;
  import uml_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_fifo_mode = 1'b0;
  logic i_rx_done = 1'b0, i_rx_store = 1'b0, i_rx_pop = 1'b0, i_rx_empty = 1'b1;
  logic i_rx_parity_bad = 1'b0, i_rx_frame_bad = 1'b0, i_rx_break = 1'b0, i_rx_full = 1'b0;
  logic i_tx_hold_empty = 1'b1, i_tx_shift_empty = 1'b1, i_tx_serial = 1'b1, i_serial_in = 1'b1;
  logic i_port_irq = 1'b0, i_line_irq_en = 1'b1, i_holding_empty_irq_en = 1'b1, i_modem_irq_en = 1'b1;
  uml_addr_type i_addr = 3'h0;
  uml_byte_type i_wr_data = 8'h00, o_rd_data, v;
  logic o_serial_out, o_rx_serial, o_loopback, o_terminal_ready_pin_n, o_request_send_pin_n;
  logic o_line_irq_req, o_holding_empty_irq_req, o_modem_irq_req, o_irq, o_irq_oe;
  logic i_clear_send_pin_n, i_set_ready_pin_n, i_ring_pin_n, i_carrier_pin_n;
  logic slow = 1'b0, pend = 1'b0;
  logic [1:0] tog = 2'h0;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int bad_count = 0, checked = 0, seed = 4594;
  uml_top uut (.*);
  uml_modem partner (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_toggle(tog),
    .i_terminal_ready_pin_n(o_terminal_ready_pin_n), .i_request_send_pin_n(o_request_send_pin_n),
    .o_clear_send_pin_n(i_clear_send_pin_n), .o_set_ready_pin_n(i_set_ready_pin_n),
    .o_ring_pin_n(i_ring_pin_n), .o_carrier_pin_n(i_carrier_pin_n));
  always #50 i_clk = ~i_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic cmp(input uml_byte_type g, input uml_byte_type x, input uml_byte_type m,
    input string s);
    checked++;
    if (((g ^ x) & m) !== 8'h00) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, x);
    end
  endtask : cmp
  // one idle edge after each strobe, so no strobe is driven twice in one step
  task automatic wr(input uml_addr_type a, input uml_byte_type d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    tick(1);
    i_wr <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input uml_addr_type a, input uml_byte_type x, input uml_byte_type m);
    exp_q.push_back({m, x});
    i_addr <= a;
    i_rd <= 1'b1;
    tick(1);
    i_rd <= 1'b0;
    tick(1);
  endtask : rd
  task automatic pulse(input logic [3:0] q, input logic store);
    {i_rx_break, i_rx_frame_bad, i_rx_parity_bad, i_rx_full} <= q;
    i_rx_done <= 1'b1;
    i_rx_store <= store;
    tick(1);
    i_rx_done <= 1'b0;
    i_rx_store <= 1'b0;
    tick(1);
  endtask : pulse
  task automatic modem(input logic [1:0] t, input uml_byte_type x);
    tog <= t;
    tick(1);
    tog <= 2'h0;
    tick(12);
    cmp({7'h0, o_modem_irq_req}, {7'h0, |x[3:0]}, 8'h01, "modem request");
    rd(3'h6, x, 8'hff);
  endtask : modem
  task automatic pop_one();
    i_rx_pop <= 1'b1;
    tick(1);
    i_rx_pop <= 1'b0;
    tick(1);
  endtask : pop_one
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  always @(posedge i_clk) begin
    if (pend) begin
      e = exp_q.pop_front();
      cmp(o_rd_data, e[7:0], e[15:8], "read data");
    end
    pend <= i_rd;
    if (!i_rst) begin
      i_tx_serial <= 1'($random(seed));
      i_serial_in <= 1'($random(seed));
      i_port_irq <= 1'($random(seed));
      i_holding_empty_irq_en <= 1'($random(seed));
    end
  end
  initial begin
    tick(5);
    i_rst <= 1'b0;
    tick(1);
    for (int k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      wr(3'h7, v);
      wr(3'(k), ~v);
      rd(3'h7, v, 8'hff);
      rd(3'(k), 8'h00, 8'hff);
    end
    wr(3'h4, 8'hff);
    tick(4);
    rd(3'h4, 8'h1f, 8'hff);
    rd(3'h6, 8'hf0, 8'hf0);
    wr(3'h4, 8'h10);
    modem(2'h0, 8'h0f);
    wr(3'h4, 8'h00);
    tick(12);
    rd(3'h6, 8'h00, 8'hff);
    slow <= 1'($random(seed));
    wr(3'h4, 8'h03);
    modem(2'h0, 8'h33);
    modem(2'h1, 8'h70);
    modem(2'h1, 8'h34);
    modem(2'h2, 8'hb8);
    for (int k = 0; k < 4; k++) begin
      {i_rx_empty, i_tx_hold_empty, i_tx_shift_empty} <= 3'($random(seed));
      pulse(4'h1 << k, 1'b0);
      v = {1'b0, i_tx_hold_empty & i_tx_shift_empty, i_tx_hold_empty, 4'h0, ~i_rx_empty};
      rd(3'h5, v | (8'h02 << k), 8'hff);
      rd(3'h5, v, 8'hff);
    end
    i_fifo_mode <= 1'b1;
    pulse(4'h4, 1'b1);
    rd(3'h5, 8'h88, 8'h9e);
    pop_one();
    rd(3'h5, 8'h80, 8'h9e);
    rd(3'h5, 8'h00, 8'h9e);
    pulse(4'h1, 1'b0);
    rd(3'h5, 8'h02, 8'h9e);
    pulse(4'h0, 1'b1);
    pulse(4'h2, 1'b1);
    rd(3'h5, 8'h80, 8'h9e);
    pop_one();
    rd(3'h5, 8'h84, 8'h9e);
    pop_one();
    rd(3'h5, 8'h80, 8'h9e);
    rd(3'h5, 8'h00, 8'h9e);
    tick(2);
    final_report();
  end
  initial begin
    tick(20000);
    bad_count++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
